// file: inc/prcl_map.svh
// Constants for the presettable ripple counter and latch.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PRCL_MAP_SVH
`define PRCL_MAP_SVH
`define PRCL_WIDTH 4
`define PRCL_HI_WIDTH 3
`define PRCL_RESET_VALUE 4'h0
`define PRCL_LO_BIT 0
`endif

// file: inc/prcl_pkg.sv
// Types for the presettable ripple counter and latch.
// Assumes prcl_map.svh is on the include path.
`include "prcl_map.svh"
package prcl_pkg;
   typedef struct packed {
      logic clear_n;
      logic load_n;
      logic [`PRCL_WIDTH-1:0] data;
   } prcl_ctrl_t;
   typedef enum logic [1:0] {PRCL_CLEAR, PRCL_LOAD, PRCL_COUNT} prcl_mode_t;
endpackage

// file: rtl/prcl_sync.sv
// Two-flop synchroniser with falling-edge detector for a pin clock.
// Assumes i_pin is asynchronous to i_sys_clk.
`timescale 1ns/1ps
module prcl_sync
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_pin,
   output logic o_level,
   output logic o_fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
   assign o_level = sync_r;
   // Only the second stage and its delayed copy feed the edge detector.
   assign o_fall = prev_r & ~sync_r;
endmodule

// file: rtl/prcl_counter.sv
// Presettable four-stage counter and transparent latch, modelled on one clock.
// Assumes all pins but i_sys_clk and i_reset are asynchronous; each of those passes two flops before use.
//
// Functional notes
// [RULE1] Four stages: a divide-by-two stage and a divide-by-eight stage, separate clocks.
// [RULE2] Load strobe low makes outputs equal data inputs regardless of clocks.
// [RULE3] While load strobe stays low, outputs follow data inputs continuously.
// [RULE4] Strobe high and clocks idle: outputs hold their value.
// [RULE5] Each stage advances only on the falling edge of its clock.
// [RULE6] Clear low forces all outputs low regardless of clocks.
// [RULE7] Outside logic routes first-stage output to second clock for binary count.
// [RULE8] Clear wins over load when both are asserted.
`timescale 1ns/1ps
`include "prcl_map.svh"
module prcl_counter
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clk1,
   input wire logic i_clk2,
   input wire logic i_load_n,
   input wire logic i_clear_n,
   input wire logic [`PRCL_WIDTH-1:0] i_data,
   output logic [`PRCL_WIDTH-1:0] o_q
);
   ////////////////////////////////////////////////////////////////////////////
   prcl_pkg::prcl_ctrl_t ctrl_m_r;
   prcl_pkg::prcl_ctrl_t ctrl_r;
   prcl_pkg::prcl_mode_t mode;
   logic fall1;
   logic fall2;
   logic [`PRCL_WIDTH-1:0] q_r;
   logic [`PRCL_WIDTH-1:0] q_nxt;
   logic lo_nxt;
   logic [`PRCL_HI_WIDTH-1:0] hi_nxt;
   logic level1;
   logic level2;

   // Limitation: the data bits cross without a handshake, so a data change that
   // straddles a sample can show a mixed value for one cycle before it settles.
   // Each control pin crosses through two flops before any logic reads it.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         ctrl_m_r <= '{clear_n: 1'b1, load_n: 1'b1, data: `PRCL_RESET_VALUE};
         ctrl_r <= '{clear_n: 1'b1, load_n: 1'b1, data: `PRCL_RESET_VALUE};
      end
      else
      begin
         ctrl_m_r <= '{clear_n: i_clear_n, load_n: i_load_n, data: i_data};
         ctrl_r <= ctrl_m_r;
      end
   end

   prcl_sync u_sync1
   (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_pin(i_clk1),
      .o_level(level1),
      .o_fall(fall1)
   );

   prcl_sync u_sync2
   (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_pin(i_clk2),
      .o_level(level2),
      .o_fall(fall2)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clear beats load, load beats counting.
   assign mode = !ctrl_r.clear_n ? prcl_pkg::PRCL_CLEAR : // RULE8 RULE6
                 !ctrl_r.load_n ? prcl_pkg::PRCL_LOAD : prcl_pkg::PRCL_COUNT;
   // The two stages are independent; chaining them is left to outside wiring.
   assign lo_nxt = fall1 ? ~q_r[`PRCL_LO_BIT] : q_r[`PRCL_LO_BIT]; // RULE1 RULE5
   assign hi_nxt = fall2 ? q_r[`PRCL_WIDTH-1:1] + 3'h1 : q_r[`PRCL_WIDTH-1:1]; // RULE1 RULE5

   always_comb
   begin
      q_nxt = q_r; // RULE4
      unique case (mode)
         prcl_pkg::PRCL_CLEAR: q_nxt = `PRCL_RESET_VALUE; // RULE6
         prcl_pkg::PRCL_LOAD: q_nxt = ctrl_r.data; // RULE2 RULE3
         prcl_pkg::PRCL_COUNT: q_nxt = {hi_nxt, lo_nxt};
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
         q_r <= `PRCL_RESET_VALUE;
      else
         q_r <= q_nxt;
   end

   // The outputs come straight from flops, so a mode change never glitches them.
   // The price is latency: a pin change shows three system cycles later.
   assign o_q = q_r;

   ////////////////////////////////////////////////////////////////////////////
   // The output flops add latency, so every check looks one cycle after its cause.
   AST_CLEAR_LOW: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE6
      !ctrl_r.clear_n |=> (o_q == 4'h0))
      else $error("Output not low after clear.");
   AST_CLEAR_WINS: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE8
      (!ctrl_r.clear_n && !ctrl_r.load_n && ctrl_r.data != 4'h0) |=> (o_q == 4'h0))
      else $error("Load overrode clear.");
   AST_LOAD_DATA: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE2
      (ctrl_r.clear_n && !ctrl_r.load_n && (fall1 || fall2)) |=> (o_q == $past(ctrl_r.data)))
      else $error("Load ignored during clock edge.");
   AST_LATCH_TRACK: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE3
      (ctrl_r.clear_n && !ctrl_r.load_n)[*2] |=> (o_q == $past(ctrl_r.data)))
      else $error("Latch not transparent.");
   AST_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE4
      (ctrl_r.clear_n && ctrl_r.load_n && !fall1 && !fall2) |=> $stable(o_q))
      else $error("Output changed while idle.");
   AST_LO_TOGGLE: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      (ctrl_r.clear_n && ctrl_r.load_n && fall1) |=> (o_q[0] != $past(o_q[0])))
      else $error("First stage did not toggle.");
   AST_HI_STEP: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      (ctrl_r.clear_n && ctrl_r.load_n && fall2)
      |=> (o_q[3:1] == $past(o_q[3:1]) + 3'h1))
      else $error("Divide-by-eight stage did not step.");
   AST_HI_ONLY_ON_CLK2: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      (ctrl_r.clear_n && ctrl_r.load_n && !fall2) |=> $stable(o_q[3:1]))
      else $error("High stages moved without clock.");

   COV_CLEAR: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      o_q != 4'h0 ##1 !ctrl_r.clear_n);
   COV_LOAD: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      !ctrl_r.load_n ##1 ctrl_r.load_n);
   COV_WRAP: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      o_q[3:1] == 3'h7 ##1 o_q[3:1] == 3'h0);
   COV_LATCH: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      (ctrl_r.clear_n && !ctrl_r.load_n) ##1 (!ctrl_r.load_n && $changed(ctrl_r.data)));
   COV_CARRY: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      fall1 ##[1:8] fall2);

   ////////////////////////////////////////////////////////////////////////////
   // Clock activity must leave a clear or a load alone; both act as pure levels.
   AST_CLEAR_IGNORES_CLK: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE6
      (!ctrl_r.clear_n && (fall1 || fall2))
      |=> (o_q == 4'h0))
      else $error("Clock edge disturbed clear.");
   AST_LOAD_NOW: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE2
      (ctrl_r.clear_n && !ctrl_r.load_n)
      |=> (o_q == $past(ctrl_r.data)))
      else $error("Load did not reach the outputs.");

   // The stages share only the mode, so each clock must reach its own stage alone.
   AST_LO_ONLY_ON_CLK1: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      (ctrl_r.clear_n && ctrl_r.load_n && !fall1)
      |=> $stable(o_q[0]))
      else $error("First stage moved without clock.");
   AST_HI_LEAVES_LO: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      (ctrl_r.clear_n && ctrl_r.load_n && fall2 && !fall1)
      |=> (o_q[0] == $past(o_q[0])))
      else $error("Second clock moved the first stage.");
   AST_LO_LEAVES_HI: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE1
      (ctrl_r.clear_n && ctrl_r.load_n && fall1 && !fall2)
      |=> (o_q[3:1] == $past(o_q[3:1])))
      else $error("First clock moved the second stage.");

   // A pin pulse shorter than one system cycle can fall between samples and be
   // lost, so the far side must hold each clock level for two cycles at least.
   AST_CLK1_LOW_WIDTH: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      $fell(level1)
      |=> !level1)
      else $error("First clock low for under two cycles.");
   AST_CLK1_HIGH_WIDTH: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      $rose(level1)
      |=> level1)
      else $error("First clock high for under two cycles.");
   AST_CLK2_LOW_WIDTH: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      $fell(level2)
      |=> !level2)
      else $error("Second clock low for under two cycles.");
   AST_CLK2_HIGH_WIDTH: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE5
      $rose(level2)
      |=> level2)
      else $error("Second clock high for under two cycles.");

   ////////////////////////////////////////////////////////////////////////////
   // End-to-end checks from the pins, so a broken crossing cannot hide behind the
   // internal checks above. A pin is sampled at the same edge as its first flop.
   AST_PIN_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE6
      !i_clear_n
      |-> ##3 (o_q == 4'h0))
      else $error("Clear pin did not reach the outputs.");
   AST_PIN_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE2
      (i_clear_n && !i_load_n)
      |-> ##3 (o_q == $past(i_data, 3)))
      else $error("Load pin did not reach the outputs.");
   AST_RESET_ZERO: assert property (@(posedge i_sys_clk)
      i_reset
      |=> (o_q == 4'h0))
      else $error("Outputs not low after reset.");

   ////////////////////////////////////////////////////////////////////////////
   // Reference copy of the outputs taken as the block goes idle, so a hold is
   // checked over a whole idle stretch, not only from one cycle to the next.
   logic idle_w;
   logic idle_r;
   logic [`PRCL_WIDTH-1:0] hold_ref_r;
   assign idle_w = ctrl_r.clear_n && ctrl_r.load_n && !fall1 && !fall2;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         idle_r <= 1'b0;
         hold_ref_r <= `PRCL_RESET_VALUE;
      end
      else
      begin
         idle_r <= idle_w;
         if (!idle_r)
            hold_ref_r <= q_r;
      end
   end

   AST_HOLD_LONG: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RULE4
      idle_r
      |-> (o_q == hold_ref_r))
      else $error("Output drifted during an idle stretch.");
endmodule

// file: tb/prcl_ext_link.sv
// Model of the outside wiring that feeds the second-stage clock.
// Assumes the bench picks between its own clock and the first-stage output.
`timescale 1ns/1ps
module prcl_ext_link
(
   input wire logic i_route,
   input wire logic i_q0,
   input wire logic i_clk2,
   output logic o_clk2
);
   // Routing the first stage onward makes the two stages one binary chain.
   assign o_clk2 = i_route ? i_q0 : i_clk2;
endmodule

// file: tb/presettable_ripple_counter_latch_test.sv
// Bench for the presettable ripple counter and latch.
// Assumes a 3-cycle lag from any pin change to the outputs.
`timescale 1ns/1ps
module presettable_ripple_counter_latch_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk1 = 1'b1;
   logic clk2 = 1'b1;
   logic clk2_w;
   logic load_n = 1'b1;
   logic clear_n = 1'b1;
   logic route = 1'b0;
   logic [3:0] data = 4'h0;
   logic [3:0] q;
   int err_total = 0;
   int cmp_count = 0;
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   prcl_ext_link link_u (.i_route(route), .i_q0(q[0]), .i_clk2(clk2), .o_clk2(clk2_w));
   prcl_counter dut_u (.i_sys_clk(clk), .i_reset(rst), .i_clk1(clk1), .i_clk2(clk2_w),
      .i_load_n(load_n), .i_clear_n(clear_n), .i_data(data), .o_q(q));
   ////////////////////////////////////////////////////////////////////////////////
   // Waits n cycles; four, one more than the lag, let the outputs settle.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic check(input logic [3:0] exp);
      cmp_count++;
      if (q !== exp)
      begin
         err_total++;
         $display("ERROR %0t q=%h expected %h", $time, q, exp);
      end
   endtask
   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic load_track();
      load_n = 1'b0;
      data = 4'h5;
      tick(4);
      check(4'h5);
      data = 4'hA;
      tick(4);
      check(4'hA);
      clk1 = 1'b0;
      clk2 = 1'b0;
      tick(4);
      clk1 = 1'b1;
      clk2 = 1'b1;
      tick(4);
      check(4'hA);
      load_n = 1'b1;
      tick(4);
      data = 4'h3;
      tick(4);
      check(4'hA);
   endtask
   task automatic clear_win();
      load_n = 1'b0;
      data = 4'hF;
      clear_n = 1'b0;
      tick(4);
      check(4'h0);
      clear_n = 1'b1;
      tick(4);
      check(4'hF);
      load_n = 1'b1;
      clear_n = 1'b0;
      clk1 = 1'b0;
      tick(4);
      check(4'h0);
      clk1 = 1'b1;
      tick(4);
      check(4'h0);
      clear_n = 1'b1;
      tick(4);
   endtask
   // Two falls on the second clock, then one on the first: the stages stay apart.
   task automatic stage_split();
      repeat (2)
      begin
         clk2 = 1'b0;
         tick(4);
         clk2 = 1'b1;
         tick(4);
      end
      check(4'h4);
      clk1 = 1'b0;
      tick(4);
      check(4'h5);
      clk1 = 1'b1;
      tick(4);
      check(4'h5);
   endtask
   // Routing is switched while clear holds, so its edge cannot count.
   task automatic count_chain();
      clear_n = 1'b0;
      route = 1'b1;
      tick(4);
      clear_n = 1'b1;
      tick(4);
      for (int i = 1; i <= 16; i++)
      begin
         clk1 = 1'b0;
         tick(4);
         clk1 = 1'b1;
         tick(4);
         check(4'(i));
      end
   endtask
   initial
   begin
      tick(16);
      rst = 1'b0;
      tick(4);
      check(4'h0);
      load_track();
      clear_win();
      stage_split();
      count_chain();
      stop_test();
   end
endmodule
